// file: core/token_node_regs.sv
// Purpose: host register bank of a token-passing network node over AXI4-Lite
// Assumes: protocol engine on aclk; one write and one read at a time
// Notes:   registers are one byte in lane 0; upper data bits read zero
`timescale 1ns/1ns

module token_node_regs
  import token_node_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // write address channel
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output      logic              s_axi_awready,
  // write data channel
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output      logic              s_axi_wready,
  // write response channel
  output      logic [1:0]        s_axi_bresp,
  output      logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // read address channel
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output      logic              s_axi_arready,
  // read data channel
  output      logic [31:0]       s_axi_rdata,
  output      logic [1:0]        s_axi_rresp,
  output      logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // protocol engine side
  input  wire core_evt_s         core_evt,
  output      core_ctl_s         core_ctl
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              aw_got;
    logic              w_got;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0]        w_data;
    logic              w_lane0;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [7:0]        rdata;
    logic [7:0]        node_identity;
    logic [7:0]        tent_id;
    logic [7:0]        next_node_identity;
    logic [7:0]        status;
    logic [7:0]        diag;
    logic [7:0]        ptr_hi;
    logic [7:0]        ptr_lo;
    logic [7:0]        cfg;      // bits 1:0 unused, slot holds them
    logic [2:0]        slot;
    logic [7:0]        speed;
    logic [7:0]        timing;
    core_ctl_s         ctl;
  } regs_s;

  regs_s s_r;
  regs_s s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state

  assign s_axi_awready = s_r.awready;
  assign s_axi_wready  = s_r.wready;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rresp   = s_r.rresp;
  assign s_axi_rdata   = {24'h000000, s_r.rdata};
  assign core_ctl      = s_r.ctl;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    regs_s       n;
    logic        do_wr;
    logic        do_rd;
    logic        wr_map;
    logic        rd_map;
    logic [2:0]  wr_idx;
    logic [2:0]  rd_idx;
    logic [7:0]  wd;
    logic [7:0]  rd;
    logic [7:0]  cfg_view;
    logic        rd_diag;
    logic        rd_next;
    logic        node_zero_wr;
    n            = s_r;
    do_wr        = 1'b0;
    do_rd        = 1'b0;
    wr_map       = 1'b0;
    rd_map       = 1'b0;
    wr_idx       = 3'h0;
    rd_idx       = 3'h0;
    wd           = BYTE_ZERO;
    rd           = BYTE_ZERO;
    cfg_view     = BYTE_ZERO;
    rd_diag      = 1'b0;
    rd_next      = 1'b0;
    node_zero_wr = 1'b0;

    n.ctl.cmd_valid = 1'b0;
    n.ctl.ram_load  = 1'b0;

    // shared select bits appear in both views
    cfg_view = {s_r.cfg[7:2], s_r.slot[1:0]};

    // address and data are taken in either order and held until used
    if (s_axi_awvalid && s_r.awready) begin
      n.aw_addr = s_axi_awaddr;
      n.aw_got  = 1'b1;
    end
    if (s_axi_wvalid && s_r.wready) begin
      n.w_data  = s_axi_wdata[7:0];
      n.w_lane0 = s_axi_wstrb[0];
      n.w_got   = 1'b1;
    end

    // write acts once both halves are held
    do_wr  = s_r.aw_got && s_r.w_got && !s_r.bvalid;
    wr_idx = s_r.aw_addr[4:2];
    wr_map = (s_r.aw_addr >> 5) == '0;
    wd     = s_r.w_data;
    if (do_wr) begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = wr_map ? RESP_OKAY : RESP_DECERR;
    end else if (s_r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end

    // register writes; only lane 0 carries a register
    if (do_wr && wr_map && s_r.w_lane0) begin
      case (wr_idx)
        IDX_DIAG: begin
          // code is passed on unchecked; host sends defined ones only
          n.ctl.cmd_valid = 1'b1;
          n.ctl.cmd_code  = wd;
        end
        IDX_PTR_HI: begin
          n.ptr_hi = wd;
        end
        IDX_PTR_LO: begin
          n.ptr_lo        = wd;
          n.ctl.ram_addr  = {s_r.ptr_hi[2:0], wd};
          n.ctl.ram_load  = 1'b1;
        end
        IDX_SLOT: begin
          n.slot = wd[2:0];
        end
        IDX_CFG: begin
          n.cfg       = wd;
          n.slot[1:0] = wd[1:0];
          n.slot[2]   = 1'b0;
        end
        IDX_SHARED: begin
          case (s_r.slot)
            SUB_TENT:   n.tent_id = wd;
            SUB_NODE: begin
              n.node_identity    = wd;
              node_zero_wr = (wd == BYTE_ZERO);
            end
            SUB_SPEED:  n.speed  = wd;
            SUB_TIMING: n.timing = wd;
            default:    ; // read-only successor, test register and spare selections
          endcase
        end
        default: ; // mask and data port are outside this bank
      endcase
    end

    // read: answer comes one cycle after the address is taken
    do_rd  = s_axi_arvalid && s_r.arready;
    rd_idx = s_axi_araddr[4:2];
    rd_map = (s_axi_araddr >> 5) == '0;
    if (do_rd) begin
      case (rd_idx)
        IDX_STATUS: rd = s_r.status;
        IDX_DIAG: begin
          rd      = s_r.diag;
          rd_diag = rd_map;
        end
        IDX_PTR_HI: rd = s_r.ptr_hi;
        IDX_PTR_LO: rd = s_r.ptr_lo;
        IDX_SLOT:   rd = {5'h00, s_r.slot};
        IDX_CFG:    rd = cfg_view;
        IDX_SHARED: begin
          case (s_r.slot)
            SUB_TENT:   rd = s_r.tent_id;
            SUB_NODE:   rd = s_r.node_identity;
            SUB_SPEED:  rd = s_r.speed;
            SUB_NEXT: begin
              rd      = s_r.next_node_identity;
              rd_next = rd_map;
            end
            SUB_TIMING: rd = s_r.timing;
            default:    rd = BYTE_ZERO;
          endcase
        end
        default: rd = BYTE_ZERO;
      endcase
      n.rvalid = 1'b1;
      n.rdata  = rd_map ? rd : BYTE_ZERO;
      n.rresp  = rd_map ? RESP_OKAY : RESP_DECERR;
    end else if (s_r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end

    // successor from the core; register is read-only to the host
    if (core_evt.next_valid) begin
      n.next_node_identity = core_evt.next_node_identity;
    end

    // status follows the core; writing zero identity flags power-on
    n.status = (s_r.status & ~core_evt.status_clr) | core_evt.status_set;
    if (node_zero_wr) begin
      n.status[ST_POR_BIT] = 1'b1;
    end

    // clears first, then sets, so an event in a clearing cycle survives
    if (rd_diag) begin
      n.diag = s_r.diag & ~DG_RDCLR_MASK;
    end
    if (core_evt.por_clear) begin
      n.diag[DG_EXCESSIVE_NAK_FLAG_BIT] = 1'b0;
    end
    if (rd_next) begin
      n.diag[DG_NEWNEXT_BIT] = 1'b0;
    end
    n.diag[7:2] = n.diag[7:2] | core_evt.diag_set;
    if (core_evt.next_valid) begin
      n.diag[DG_NEWNEXT_BIT] = 1'b1;
    end
    n.diag[0] = 1'b0;

    // software reset holds while its bit is set; identity, configuration
    // and setup survive it
    if (s_r.cfg[CFG_SRST_BIT]) begin
      n.next_node_identity = BYTE_ZERO;
      n.status  = STATUS_RST;
      n.diag    = DIAG_RST;
    end

    // ready flags registered so the ports come from flops
    n.awready = !n.aw_got && !n.bvalid;
    n.wready  = !n.w_got && !n.bvalid;
    n.arready = !n.rvalid;

    // controls towards the core
    n.ctl.awake     = n.node_identity != BYTE_ZERO;
    n.ctl.rx_enable = n.ctl.awake;
    n.ctl.tx_join   = n.ctl.awake && n.cfg[CFG_TRANSMIT_ENABLE_BIT_BIT];
    n.ctl.soft_reset    = n.cfg[CFG_SRST_BIT];
    n.ctl.ram_read_mode = n.ptr_hi[PH_RDDATA_BIT];
    n.ctl.ram_autoinc   = n.ptr_hi[PH_AUTOINC_BIT];
    n.ctl.chain_en      = n.cfg[CFG_CHAIN_BIT];
    n.ctl.ext_timeout   = n.cfg[CFG_ET_LSB +: 2];
    n.ctl.backplane     = n.cfg[CFG_BPLANE_BIT];
    n.ctl.slow_arb      = n.speed[SP_SLOWARB_BIT];
    n.ctl.slow_rate     = n.speed[SP_SLOWRATE_BIT];
    n.ctl.rcv_all       = n.speed[SP_RCVALL_BIT];
    n.ctl.pulse_mode    = n.speed[SP_PULSE_BIT];
    n.ctl.clock_prescale_sel   = n.timing[TM_CKUP_LSB +: 2];
    n.ctl.fast_read_select     = n.timing[TM_FASTRD_BIT];
    n.ctl.enhanced_timing_flag = n.timing[TM_EF_BIT];
    n.ctl.skip_idle_wait       = n.timing[TM_SKIP_IDLE_WAIT_BIT];
    n.ctl.ram_init_allowed = n.timing[TM_SKIP_IDLE_WAIT_BIT]
                             || core_evt.line_idle;

    // timeout table, doubled at the halved data rate
    case (n.timing[TM_RCN_LSB +: 2])
      2'h0: begin
        n.ctl.recon_timeout_ms = RCN_MS_0;
        n.ctl.recon_node_limit = RCN_NODES_0;
      end
      2'h1: begin
        n.ctl.recon_timeout_ms = RCN_MS_1;
        n.ctl.recon_node_limit = RCN_NODES_1;
      end
      2'h2: begin
        n.ctl.recon_timeout_ms = RCN_MS_2;
        n.ctl.recon_node_limit = RCN_NODES_2;
      end
      default: begin
        // only valid when some node holds identity 255
        n.ctl.recon_timeout_ms = RCN_MS_3;
        n.ctl.recon_node_limit = RCN_NODES_3;
      end
    endcase
    if (n.ctl.slow_rate) begin
      n.ctl.recon_timeout_ms = n.ctl.recon_timeout_ms << 1;
    end

    s_nxt = n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; hardware reset sets every field

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r         <= '0;
      s_r.node_identity <= BYTE_ZERO;
      s_r.tent_id <= BYTE_ZERO;
      s_r.next_node_identity <= BYTE_ZERO;
      s_r.status  <= STATUS_RST;
      s_r.diag    <= DIAG_RST;
      s_r.cfg     <= {CFG_RST[7:2], 2'b00};
      s_r.slot    <= {1'b0, CFG_RST[1:0]};
      s_r.speed   <= BYTE_ZERO;
      s_r.timing  <= BYTE_ZERO;
      s_r.ctl.ext_timeout      <= CFG_RST[CFG_ET_LSB +: 2];
      s_r.ctl.recon_timeout_ms <= RCN_MS_0;
      s_r.ctl.recon_node_limit <= RCN_NODES_0;
      s_r.ctl.ram_init_allowed <= 1'b0;
      s_r.awready <= 1'b0;
      s_r.wready  <= 1'b0;
      s_r.arready <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

// file: core/token_node_pkg.sv
// Purpose: shared constants and carriers for the node host register bank
// Assumes: 8-bit registers placed one per 32-bit word, byte lane 0
// Notes:   printed offsets are register indices; byte address = 4 x index
package token_node_pkg;

  // register indices on the bus (byte address is index times four)
  localparam logic [2:0] IDX_STATUS = 3'h0; // read status, write mask
  localparam logic [2:0] IDX_DIAG   = 3'h1; // read diag, write command
  localparam logic [2:0] IDX_PTR_HI = 3'h2;
  localparam logic [2:0] IDX_PTR_LO = 3'h3;
  localparam logic [2:0] IDX_DATA   = 3'h4;
  localparam logic [2:0] IDX_SLOT   = 3'h5;
  localparam logic [2:0] IDX_CFG    = 3'h6;
  localparam logic [2:0] IDX_SHARED = 3'h7;

  // selections inside the shared slot
  localparam logic [2:0] SUB_TENT   = 3'h0;
  localparam logic [2:0] SUB_NODE   = 3'h1;
  localparam logic [2:0] SUB_SPEED  = 3'h2;
  localparam logic [2:0] SUB_NEXT   = 3'h3;
  localparam logic [2:0] SUB_TIMING = 3'h4;

  // values after reset (undefined bits taken as zero)
  localparam logic [7:0] STATUS_RST = 8'h91;
  localparam logic [7:0] DIAG_RST   = 8'h00;
  localparam logic [7:0] CFG_RST    = 8'h18;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;

  // field positions
  localparam int CFG_SRST_BIT    = 7;
  localparam int CFG_CHAIN_BIT   = 6;
  localparam int CFG_TRANSMIT_ENABLE_BIT_BIT    = 5;
  localparam int CFG_ET_LSB      = 3;
  localparam int CFG_BPLANE_BIT  = 2;
  localparam int ST_POR_BIT      = 4;
  localparam int DG_EXCESSIVE_NAK_FLAG_BIT   = 3;
  localparam int DG_NEWNEXT_BIT  = 1;
  localparam logic [7:0] DG_RDCLR_MASK = 8'hF4; // all but excessive_nak_flag, newnext
  localparam int SP_SLOWARB_BIT  = 0;
  localparam int SP_SLOWRATE_BIT = 1;
  localparam int SP_RCVALL_BIT   = 4;
  localparam int SP_PULSE_BIT    = 7;
  localparam int TM_FASTRD_BIT   = 7;
  localparam int TM_CKUP_LSB     = 4;
  localparam int TM_EF_BIT       = 3;
  localparam int TM_SKIP_IDLE_WAIT_BIT   = 2;
  localparam int TM_RCN_LSB      = 0;
  localparam int PH_RDDATA_BIT   = 7;
  localparam int PH_AUTOINC_BIT  = 6;

  // reconfiguration timeouts at the full data rate, in ms
  localparam logic [13:0] RCN_MS_0 = 14'd6720;
  localparam logic [13:0] RCN_MS_1 = 14'd1680;
  localparam logic [13:0] RCN_MS_2 = 14'd840;
  localparam logic [13:0] RCN_MS_3 = 14'd420;
  localparam logic [7:0]  RCN_NODES_0 = 8'd255;
  localparam logic [7:0]  RCN_NODES_1 = 8'd64;
  localparam logic [7:0]  RCN_NODES_2 = 8'd32;
  localparam logic [7:0]  RCN_NODES_3 = 8'd16;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // events from the protocol engine, same clock
  typedef struct packed {
    logic       next_valid;  // successor changed
    logic [7:0] next_node_identity;
    logic [7:0] status_set;
    logic [7:0] status_clr;
    logic [7:2] diag_set;
    logic       por_clear;   // power-on clear-flags command done
    logic       line_idle;
  } core_evt_s;

  // controls towards the protocol engine
  typedef struct packed {
    logic        awake;
    logic        tx_join;
    logic        rx_enable;
    logic        soft_reset;
    logic        cmd_valid;
    logic [7:0]  cmd_code;
    logic        ram_load;
    logic [10:0] ram_addr;
    logic        ram_read_mode;
    logic        ram_autoinc;
    logic        chain_en;
    logic [1:0]  ext_timeout;
    logic        backplane;
    logic        slow_arb;
    logic        slow_rate;
    logic        rcv_all;
    logic        pulse_mode;
    logic [1:0]  clock_prescale_sel;
    logic        fast_read_select;
    logic        enhanced_timing_flag;
    logic        skip_idle_wait;
    logic        ram_init_allowed;
    logic [13:0] recon_timeout_ms;
    logic [7:0]  recon_node_limit;
  } core_ctl_s;

endpackage

// file: bench/regs_properties.sv
// Purpose: timing checks on the ports of the node register bank
// Assumes: one clock aclk, synchronous active-low aresetn
// Notes:   bound to every instance of the bank
`timescale 1ns/1ns
module regs_properties
  import token_node_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  // read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  // engine side
  input wire core_evt_s         core_evt,
  input wire core_ctl_s         core_ctl
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////
  // asleep means no joining and no listening
  sleep_gate_a: assert property (
    !core_ctl.awake |-> !core_ctl.tx_join && !core_ctl.rx_enable)
    else $error("core active while identity is zero");
  rx_awake_a: assert property (core_ctl.rx_enable == core_ctl.awake)
    else $error("receiver does not follow wake state");
  // read answer one cycle after the address is taken
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late or address still open");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped before taken");
  write_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped before taken");
  // strobes towards the engine last one cycle
  cmd_pulse_a: assert property (core_ctl.cmd_valid |=> !core_ctl.cmd_valid)
    else $error("command strobe longer than one cycle");
  load_pulse_a: assert property (core_ctl.ram_load |=> !core_ctl.ram_load)
    else $error("pointer load strobe longer than one cycle");
  // shortest node limit pairs with the shortest timeout, scaled
  timeout_pair_a: assert property (
    core_ctl.recon_node_limit == RCN_NODES_3 |-> core_ctl.recon_timeout_ms
    == (core_ctl.slow_rate ? RCN_MS_2 : RCN_MS_3))
    else $error("timeout does not match node limit");
  // main traffic seen
  read_c: cover property (s_axi_arvalid && s_axi_arready);
  cmd_c: cover property (core_ctl.cmd_valid);
  load_c: cover property (core_ctl.ram_load);
endmodule
bind token_node_regs regs_properties #(.ADDR_W(ADDR_W)) props (.*);

// file: bench/engine_model.sv
// Purpose: protocol engine stand-in on the far side of the bank
// Assumes: same clock as the bank; events are one-cycle pulses, line_idle is a held level
// Notes:   records the last command and the last ram address loaded
`timescale 1ns/1ns
module engine_model
  import token_node_pkg::*;
(
  // clock
  input  wire logic      aclk,
  // bank side
  input  wire core_ctl_s core_ctl,
  output      core_evt_s core_evt
);
  logic [7:0]  cmd;
  logic [10:0] addr;
  ////////////////////////////////////////////////////////////////
  // quiet engine, busy line until told otherwise
  initial core_evt = '0;
  // capture strobes from the bank
  always @(posedge aclk) begin
    if (core_ctl.cmd_valid) cmd <= core_ctl.cmd_code;
    if (core_ctl.ram_load) addr <= core_ctl.ram_addr;
  end
  // successor change; id is scrambled after so no stale value lingers
  task automatic hop(input logic [7:0] id);
    @(posedge aclk);
    core_evt.next_node_identity    <= id;
    core_evt.next_valid <= 1'b1;
    @(posedge aclk);
    core_evt.next_valid <= 1'b0;
    core_evt.next_node_identity    <= ~id;
  endtask
  // diagnostic events
  task automatic diag(input logic [7:2] b);
    @(posedge aclk);
    core_evt.diag_set <= b;
    @(posedge aclk);
    core_evt.diag_set <= '0;
  endtask
  // power-on clear-flags command completed
  task automatic por;
    @(posedge aclk);
    core_evt.por_clear <= 1'b1;
    @(posedge aclk);
    core_evt.por_clear <= 1'b0;
  endtask
  // status events; set and clear may meet in one cycle
  task automatic stat(input logic [7:0] s, input logic [7:0] c);
    @(posedge aclk);
    core_evt.status_set <= s;
    core_evt.status_clr <= c;
    @(posedge aclk);
    core_evt.status_set <= '0;
    core_evt.status_clr <= '0;
  endtask
  task automatic idle(input logic v);
    @(posedge aclk);
    core_evt.line_idle <= v;
  endtask
endmodule

// file: bench/tb_top.sv
// Purpose: register-level tests of the node register bank
// Assumes: 250 MHz aclk, bus tasks sample answers before each edge
// Notes:   controls are checked mid-cycle, after the edge has settled
`timescale 1ns/1ns
module tb_top
  import token_node_pkg::*;
;
  localparam logic [13:0] TMO [4] = '{RCN_MS_0, RCN_MS_1, RCN_MS_2, RCN_MS_3};
  localparam logic [7:0]  LIM [4] = '{RCN_NODES_0, RCN_NODES_1,
                                      RCN_NODES_2, RCN_NODES_3};
  logic        aclk, aresetn;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, got;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, rsp;
  logic [3:0]  wstrb;
  core_evt_s   evt;
  core_ctl_s   ctl;
  int          miscompares, compares, i;
  ////////////////////////////////////////////////////////////////
  initial aclk = 1'b0;
  always #2 aclk = ~aclk;
  token_node_regs dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .core_evt(evt),
    .core_ctl(ctl));
  engine_model pm (.aclk(aclk), .core_ctl(ctl), .core_evt(evt));
  ////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // answers are sampled mid-cycle, they only change on rising edges
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ta, tw, tb;
    int   n;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ta  = awvalid && awready;
      tw  = wvalid && wready;
      tb  = bvalid;
      rsp = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) break;
    end
    bready <= 1'b0;
    if (n == 50) begin
      miscompares++;
      conclude();
    end
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    int   n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ta  = arvalid && arready;
      tr  = rvalid;
      got = rdata;
      rsp = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) break;
    end
    rready <= 1'b0;
    if (n == 50) begin
      miscompares++;
      conclude();
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'h1;
    miscompares = 0;
    compares = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00); chk(got, 32'h91);
    rd(8'h04); chk(got, 32'h00);
    rd(8'h18); chk(got, 32'h18);
    chk(32'(ctl.awake), 32'h0);
    chk(32'(ctl.ext_timeout), 32'h3);
    // slot bits shared with configuration, bit two cleared by it
    wr(8'h14, 8'h06); rd(8'h14); chk(got, 32'h06);
    wr(8'h18, 8'h19); rd(8'h14); chk(got, 32'h01);
    rd(8'h1C); chk(got, 32'h00);
    wr(8'h1C, 8'h05); @(negedge aclk);
    chk(32'({ctl.awake, ctl.tx_join, ctl.rx_enable}), 32'h5);
    wr(8'h18, 8'h39); @(negedge aclk);
    chk(32'(ctl.tx_join), 32'h1);
    // successor update, flag, read-clear through slot three
    pm.hop(8'h2A); rd(8'h04); chk(got, 32'h02);
    wr(8'h14, 8'h03); rd(8'h1C); chk(got, 32'h2A);
    rd(8'h04); chk(got, 32'h00);
    wr(8'h1C, 8'hFF); rd(8'h1C); chk(got, 32'h2A);
    pm.diag(6'h3F); rd(8'h04); chk(got, 32'hFC);
    rd(8'h04); chk(got, 32'h08);
    pm.por(); rd(8'h04); chk(got, 32'h00);
    // software reset keeps identity and configuration
    pm.hop(8'h33); pm.diag(6'h3F);
    wr(8'h18, 8'hFD); @(negedge aclk);
    chk(32'({ctl.soft_reset, ctl.chain_en, ctl.ext_timeout,
             ctl.backplane}), 32'h1F);
    wr(8'h18, 8'h39);
    rd(8'h04); chk(got, 32'h00);
    rd(8'h1C); chk(got, 32'h05);
    rd(8'h18); chk(got, 32'h39);
    wr(8'h14, 8'h03); rd(8'h1C); chk(got, 32'h00);
    wr(8'h00, 8'hFF); rd(8'h00); chk(got, 32'h91);
    // pointer pair, low write loads the address
    wr(8'h08, 8'h45); wr(8'h0C, 8'h67); @(negedge aclk);
    chk(32'(pm.addr), 32'h567);
    wr(8'h0C, 8'h01); @(negedge aclk); chk(32'(pm.addr), 32'h501);
    rd(8'h08); chk(got, 32'h45);
    chk(32'({ctl.ram_read_mode, ctl.ram_autoinc}), 32'h1);
    // lane 0 not strobed: the write must leave the register alone
    wstrb <= 4'h0;
    wr(8'h08, 8'h99); rd(8'h08); chk(got, 32'h45);
    wstrb <= 4'h1;
    wr(8'h04, 8'h0C); @(negedge aclk); chk(32'(pm.cmd), 32'h0C);
    // every timeout code, with successor 255 on the network
    pm.hop(8'hFF); wr(8'h14, 8'h04);
    for (i = 0; i < 4; i++) begin
      wr(8'h1C, 8'h8C | 8'(i * 17)); @(negedge aclk);
      chk(32'(ctl.recon_timeout_ms), 32'(TMO[i]));
      chk(32'(ctl.recon_node_limit), 32'(LIM[i]));
      chk(32'(ctl.clock_prescale_sel), 32'(i));
      chk(32'({ctl.fast_read_select, ctl.enhanced_timing_flag}), 32'h3);
      chk(32'(ctl.ram_init_allowed), 32'h1);
      chk(32'(ctl.skip_idle_wait), 32'h1);
    end
    wr(8'h1C, 8'h03); @(negedge aclk);
    chk(32'(ctl.ram_init_allowed), 32'h0);
    pm.idle(1'b1); repeat (2) @(posedge aclk); @(negedge aclk);
    chk(32'(ctl.ram_init_allowed), 32'h1);
    wr(8'h14, 8'h02); wr(8'h1C, 8'h93); @(negedge aclk);
    chk(32'({ctl.slow_arb, ctl.slow_rate, ctl.rcv_all, ctl.pulse_mode}),
        32'hF);
    chk(32'(ctl.recon_timeout_ms), 32'(RCN_MS_2));
    rd(8'h1C); chk(got, 32'h93);
    // status follows engine events; zero identity raises power-on
    pm.stat(8'h06, 8'h10); rd(8'h00); chk(got, 32'h87);
    wr(8'h14, 8'h01); wr(8'h1C, 8'h00); rd(8'h00); chk(got, 32'h97);
    chk(32'(ctl.awake), 32'h0);
    pm.stat(8'h02, 8'h82); rd(8'h00); chk(got, 32'h17);
    wr(8'h14, 8'h00); wr(8'h1C, 8'h5A); rd(8'h1C); chk(got, 32'h5A);
    // hardware reset mid-run clears what software reset kept
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h18); chk(got, 32'h18);
    rd(8'h1C); chk(got, 32'h00);
    wr(8'h14, 8'h01); rd(8'h1C); chk(got, 32'h00);
    wr(8'h14, 8'h02); rd(8'h1C); chk(got, 32'h00);
    wr(8'h20, 8'h11); chk(32'(rsp), 32'(RESP_DECERR));
    rd(8'h20); chk(32'(rsp), 32'(RESP_DECERR)); chk(got, 32'h0);
    conclude();
  end
endmodule
